/* rtl/pcfg_port_cfg.sv */
// Port configuration, pin priority and pin-change flags behind Wishbone
// What this block does
// - Priority field 7:6 of port 2 direction resolves port 0 peripheral conflicts.
// - Port 2 direction bits 4:0: 0 input, 1 output; reset all inputs.
// - Eight port 0 mode bits: 0 pulled, 1 tristate; reset zero.
// - Port 1 mode bits exist for pins 7..2 only; bits 1:0 read zero.
// - Port 2 mode bits 4:0: 0 pulled, 1 tristate; reset zero.
// - Port 2 pulled inputs: bit 7 selects pull-up 0 or pull-down 1.
// - Port 1 pulled inputs: bit 6 selects pull; pins 0 and 1 unpulled.
// - Port 0 pulled inputs: bit 5 selects pull-up 0 or pull-down 1.
// - Without USB, eight port 0 pending flags; reset zero; write 0 clears.
// - With USB, port 0 bit 7 is resume, bit 6 unused, 5:0 pins.
// - Eight port 1 pending flags; reset zero; write 0 clears.
// - Five port 2 pending flags at 4:0; bits 7:5 read zero.
// - Per-port edge select: 0 rising edge, 1 falling edge raises flag.
`timescale 1ns/10ps
`default_nettype none
`include "pcfg_map.svh"
module pcfg_port_cfg #(
   parameter bit USB_VARIANT = 1'b0
) (
   input  wire logic                       clock_in,      // System clock
   input  wire logic                       rst_in,        // Sync reset, high
   input  wire logic [9:0]                 wb_adr_in,     // Byte address
   input  wire logic [31:0]                wb_dat_in,     // Write data
   output logic      [31:0]                wb_dat_out,    // Read data
   input  wire logic [3:0]                 wb_sel_in,     // Byte selects
   input  wire logic                       wb_we_in,      // Write
   input  wire logic                       wb_cyc_in,     // Cycle
   input  wire logic                       wb_stb_in,     // Strobe
   output logic                            wb_ack_out,    // Acknowledge
   input  wire logic [7:0]                 p0_pin_in,     // Port 0 pins
   input  wire logic [7:0]                 p1_pin_in,     // Port 1 pins
   input  wire logic [4:0]                 p2_pin_in,     // Port 2 pins
   input  wire logic [7:0]                 p0_dir_in,     // Port 0 direction
   input  wire logic [7:0]                 p1_dir_in,     // Port 1 direction
   input  wire logic                       usb_resume_in, // Resume pulse
   input  wire logic [7:0]                 ser0_want_in,  // Serial 0 pins
   input  wire logic [7:0]                 ser1_want_in,  // Serial 1 pins
   input  wire logic [7:0]                 tmr_lo_want_in,// Timer ch 0/1
   input  wire logic [7:0]                 tmr_hi_want_in,// Timer ch 2
   output pcfg_pkg::pcfg_owner_t [7:0]     p0_owner_out,  // Pin owner
   output logic      [4:0]                 port2_pin_direction_out, // 1 out
   output logic      [7:0]                 p0_pull_up_out,   // Pull-ups
   output logic      [7:0]                 p0_pull_down_out, // Pull-downs
   output logic      [7:0]                 p1_pull_up_out,   // Pull-ups
   output logic      [7:0]                 p1_pull_down_out, // Pull-downs
   output logic      [4:0]                 p2_pull_up_out,   // Pull-ups
   output logic      [4:0]                 p2_pull_down_out, // Pull-downs
   output logic                            irq_out        // Interrupt
);
   import pcfg_pkg::*;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   logic [7:0] port2_direction_priority_reg;
   logic [7:0] p0mode_reg;
   logic [7:0] p1mode_reg;
   logic [7:0] p2mode_reg;
   logic [7:0] p0flag_reg;
   logic [7:0] p1flag_reg;
   logic [4:0] p2flag_reg;
   logic [2:0] edge_reg;
   logic [2:0] stat_reg;
   logic [2:0] mask_reg;
   logic [7:0] p0flag_next;
   logic [7:0] p1flag_next;
   logic [4:0] p2flag_next;
   logic [2:0] stat_next;
   logic [7:0] rdata;
   pcfg_owner_t [7:0] owner_next;

   // Bus decode: ack one cycle after the request, commit on the ack edge
   wire       req      = wb_cyc_in & wb_stb_in;
   wire       commit   = req & wb_ack_out;
   wire       wr       = commit & wb_we_in & wb_sel_in[0];
   wire       rd       = commit & ~wb_we_in;
   wire [7:0] idx      = wb_adr_in[9:2];
   wire [7:0] wd       = wb_dat_in[7:0];
   wire       wr_port2_direction_priority = wr & (idx == `PCFG_IDX_P2_DIR);
   wire       wr_p0md  = wr & (idx == `PCFG_IDX_P0_MODE);
   wire       wr_p1md  = wr & (idx == `PCFG_IDX_P1_MODE);
   wire       wr_p2md  = wr & (idx == `PCFG_IDX_P2_MODE);
   wire       wr_p0fl  = wr & (idx == `PCFG_IDX_P0_FLAGS);
   wire       wr_p1fl  = wr & (idx == `PCFG_IDX_P1_FLAGS);
   wire       wr_p2fl  = wr & (idx == `PCFG_IDX_P2_FLAGS);
   wire       wr_edge  = wr & (idx == `PCFG_IDX_EDGE);
   wire       wr_mask  = wr & (idx == `PCFG_IDX_IRQ_MASK);
   wire       rd_stat  = rd & (idx == `PCFG_IDX_IRQ_STAT);

   // Pin edge events per port
   logic [7:0] p0_edge;
   logic [7:0] p1_edge;
   logic [4:0] p2_edge;

   pcfg_edge #(.W(8)) u_edge0 (
      .clock_in    (clock_in),
      .rst_in      (rst_in),
      .pin_in      (p0_pin_in),
      .fall_sel_in (edge_reg[`PCFG_EV_P0]),
      .event_out   (p0_edge)
   );
   pcfg_edge #(.W(8)) u_edge1 (
      .clock_in    (clock_in),
      .rst_in      (rst_in),
      .pin_in      (p1_pin_in),
      .fall_sel_in (edge_reg[`PCFG_EV_P1]),
      .event_out   (p1_edge)
   );
   pcfg_edge #(.W(5)) u_edge2 (
      .clock_in    (clock_in),
      .rst_in      (rst_in),
      .pin_in      (p2_pin_in),
      .fall_sel_in (edge_reg[`PCFG_EV_P2]),
      .event_out   (p2_edge)
   );

   // USB variant: bit 7 comes from resume only, pins 7 and 6 never set flags
   wire [7:0] usb_ev  = {usb_resume_in, 7'h00};
   wire [7:0] p0_set  = USB_VARIANT ?
                        ((p0_edge & `PCFG_USB_P0_MASK & ~usb_ev) | usb_ev)
                        : p0_edge;
   wire [7:0] p0_keep = wr_p0fl ? wd : `PCFG_ALL_ONES;
   wire [7:0] p1_keep = wr_p1fl ? wd : `PCFG_ALL_ONES;
   wire [4:0] p2_keep = wr_p2fl ? wd[`PCFG_DIR_HI:0] : `PCFG_FULL_CAP5;

   // Writing 0 clears, writing 1 keeps, a new edge wins over the clear
   assign p0flag_next = (p0flag_reg & p0_keep) | p0_set;
   assign p1flag_next = (p1flag_reg & p1_keep) | p1_edge;
   assign p2flag_next = (p2flag_reg & p2_keep) | p2_edge;

   // Sticky interrupt causes; a read clears, a same-cycle event survives
   wire [2:0] ev_vec = {|p2_edge, |p1_edge, |p0_set};
   assign stat_next = (rd_stat ? `PCFG_RST3 : stat_reg) | ev_vec;

   // Pending flag and status registers
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         p0flag_reg <= `PCFG_RST8;
         p1flag_reg <= `PCFG_RST8;
         p2flag_reg <= `PCFG_RST5;
         stat_reg   <= `PCFG_RST3;
      end
      else
      begin
         p0flag_reg <= p0flag_next;
         p1flag_reg <= p1flag_next;
         p2flag_reg <= p2flag_next;
         stat_reg   <= stat_next;
      end
   end

   // Configuration registers; unused bits are masked on the way in
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         port2_direction_priority_reg  <= `PCFG_RST8;
         p0mode_reg <= `PCFG_RST8;
         p1mode_reg <= `PCFG_RST8;
         p2mode_reg <= `PCFG_RST8;
         edge_reg   <= `PCFG_RST3;
         mask_reg   <= `PCFG_RST3;
      end
      else
      begin
         if (wr_port2_direction_priority)
            port2_direction_priority_reg <= wd & `PCFG_PORT2_DIRECTION_PRIORITY_MASK;
         if (wr_p0md)
            p0mode_reg <= wd;
         if (wr_p1md)
            p1mode_reg <= wd & `PCFG_P1MODE_MASK;
         if (wr_p2md)
            p2mode_reg <= wd;
         if (wr_edge)
            edge_reg <= wd[`PCFG_EV_P2:0];
         if (wr_mask)
            mask_reg <= wd[`PCFG_EV_P2:0];
      end
   end

   // Read multiplexer; unmapped indices read zero
   always_comb
   begin
      unique case (idx)
         `PCFG_IDX_P2_DIR:   rdata = port2_direction_priority_reg;
         `PCFG_IDX_P0_MODE:  rdata = p0mode_reg;
         `PCFG_IDX_P1_MODE:  rdata = p1mode_reg;
         `PCFG_IDX_P2_MODE:  rdata = p2mode_reg;
         `PCFG_IDX_P0_FLAGS: rdata = p0flag_reg;
         `PCFG_IDX_P1_FLAGS: rdata = p1flag_reg;
         `PCFG_IDX_P2_FLAGS: rdata = {3'h0, p2flag_reg};
         `PCFG_IDX_EDGE:     rdata = {5'h00, edge_reg};
         `PCFG_IDX_IRQ_STAT: rdata = {5'h00, stat_reg};
         `PCFG_IDX_IRQ_MASK: rdata = {5'h00, mask_reg};
         default:            rdata = `PCFG_RST8;
      endcase
   end

   // Bus answer: data captured with ack, ack dropped after one cycle
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_out <= req & ~wb_ack_out;
         wb_dat_out <= {24'h00_0000, rdata};
      end
   end

   // Port 0 pin arbitration, fixed fallback order for unlisted pairs
   wire [1:0] prio = port2_direction_priority_reg[`PCFG_PRIO_HI:`PCFG_PRIO_LO];
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         owner_next[i] = PCFG_OWN_NONE;
         if (tmr_lo_want_in[i] | tmr_hi_want_in[i])
            owner_next[i] = PCFG_OWN_TMR;
         if (ser1_want_in[i] && !(prio == 2'b10 && tmr_lo_want_in[i]))
            owner_next[i] = PCFG_OWN_SER1;
         if (ser0_want_in[i] && !(prio == 2'b01 && ser1_want_in[i])
             && !(prio == 2'b11 && tmr_hi_want_in[i]))
            owner_next[i] = PCFG_OWN_SER0;
      end
   end

   // Registered owner, direction and interrupt outputs
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         p0_owner_out            <= {8{PCFG_OWN_NONE}};
         port2_pin_direction_out <= `PCFG_RST5;
         irq_out                 <= 1'b0;
      end
      else
      begin
         p0_owner_out            <= owner_next;
         port2_pin_direction_out <= port2_direction_priority_reg[`PCFG_DIR_HI:0];
         irq_out                 <= |(stat_next & mask_reg);
      end
   end

   // Pad pull controls per port
   pcfg_pull #(.W(8), .CAP(`PCFG_FULL_CAP8)) u_pull0 (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .dir_in   (p0_dir_in),
      .tri_in   (p0mode_reg),
      .down_in  (p2mode_reg[`PCFG_PULL0_BIT]),
      .up_out   (p0_pull_up_out),
      .down_out (p0_pull_down_out)
   );
   pcfg_pull #(.W(8), .CAP(`PCFG_P1_PULL_CAP)) u_pull1 (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .dir_in   (p1_dir_in),
      .tri_in   (p1mode_reg),
      .down_in  (p2mode_reg[`PCFG_PULL1_BIT]),
      .up_out   (p1_pull_up_out),
      .down_out (p1_pull_down_out)
   );
   pcfg_pull #(.W(5), .CAP(`PCFG_FULL_CAP5)) u_pull2 (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .dir_in   (port2_direction_priority_reg[`PCFG_DIR_HI:0]),
      .tri_in   (p2mode_reg[`PCFG_DIR_HI:0]),
      .down_in  (p2mode_reg[`PCFG_PULL2_BIT]),
      .up_out   (p2_pull_up_out),
      .down_out (p2_pull_down_out)
   );

   // Checks next to the logic above
   a_ack_single : assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack held two cycles");
   a_port2_direction_priority_write : assert property (wr_port2_direction_priority |=>
      port2_direction_priority_reg == ($past(wd) & `PCFG_PORT2_DIRECTION_PRIORITY_MASK))
      else $error("direction write lost");
   a_p1mode_low : assert property (p1mode_reg[1:0] == 2'b00)
      else $error("port 1 mode low bits set");
   a_p2flag_read : assert property (rd && idx == `PCFG_IDX_P2_FLAGS
      |-> wb_dat_out[7:5] == 3'h0)
      else $error("port 2 flag high bits read one");
   a_p1flag_set : assert property (|p1_edge |=>
      (p1flag_reg & $past(p1_edge)) == $past(p1_edge))
      else $error("port 1 event lost");
   a_p0flag_keep : assert property (wr_p0fl && wd == 8'hFF && p0_set == 8'h00
      |=> p0flag_reg == $past(p0flag_reg))
      else $error("writing ones changed flags");
   a_p0flag_clear : assert property (wr_p0fl && (p0_set & ~wd) == 8'h00
      |=> (p0flag_reg & ~$past(wd)) == 8'h00)
      else $error("flag clear failed");
   a_usb_unused : assert property (USB_VARIANT |-> !p0flag_reg[6])
      else $error("unused flag bit set");
   a_prio_ser1 : assert property (prio == 2'b01 && ser0_want_in[0] && ser1_want_in[0]
      |=> p0_owner_out[0] == PCFG_OWN_SER1)
      else $error("priority not honoured");
   a_edge_stat : assert property (|p1_edge ##1 !rd_stat [*2] |-> stat_reg[1])
      else $error("status bit not sticky");

   // Flag, status and interrupt checks; a set wins over a clear in one cycle
   a_p0flag_set : assert property (|p0_set |=>
      (p0flag_reg & $past(p0_set)) == $past(p0_set))
      else $error("port 0 event lost");
   a_p2flag_set : assert property (|p2_edge |=>
      (p2flag_reg & $past(p2_edge)) == $past(p2_edge))
      else $error("port 2 event lost");
   a_p1flag_keep : assert property (wr_p1fl |=>
      (($past(p1flag_reg) & $past(wd)) & ~p1flag_reg) == `PCFG_RST8)
      else $error("port 1 flag lost on write");
   a_stat_clear : assert property (rd_stat && ev_vec == `PCFG_RST3 |=> stat_reg == `PCFG_RST3)
      else $error("status read did not clear");
   a_irq_level : assert property (irq_out == |(stat_reg & $past(mask_reg)))
      else $error("interrupt level wrong");

   // Bit 7 of the USB build rises only on a resume pulse, never from pin 7
   a_resume_only : assert property (USB_VARIANT && !usb_resume_in
      && !p0flag_reg[`PCFG_USB_BIT] |=> !p0flag_reg[`PCFG_USB_BIT])
      else $error("flag 7 set without resume");

   // Configuration, priority and bus timing checks
   a_prio_tmr_lo : assert property (prio == 2'b10 && tmr_lo_want_in[1] && ser1_want_in[1]
      && !ser0_want_in[1] |=> p0_owner_out[1] == PCFG_OWN_TMR)
      else $error("timer 0/1 priority lost");
   a_prio_tmr_hi : assert property (prio == 2'b11 && tmr_hi_want_in[2] && ser0_want_in[2]
      && !ser1_want_in[2] |=> p0_owner_out[2] == PCFG_OWN_TMR)
      else $error("timer 2 priority lost");
   a_port2_direction_priority_out : assert property (wr_port2_direction_priority |=> ##1
      port2_pin_direction_out == port2_direction_priority_reg[`PCFG_DIR_HI:0])
      else $error("direction output stale");
   a_p0mode_write : assert property (wr_p0md |=> p0mode_reg == $past(wd))
      else $error("port 0 mode write lost");
   a_edge_write : assert property (wr_edge |=>
      {5'h00, edge_reg} == ($past(wd) & `PCFG_EDGE_MASK))
      else $error("edge select write lost");
   a_ack_reply : assert property (req && !wb_ack_out |=> wb_ack_out)
      else $error("request not acknowledged");
endmodule
`default_nettype wire

/* rtl/pcfg_map.svh */
// Register indices, field positions and reset values of the port block
`ifndef PCFG_MAP_SVH
`define PCFG_MAP_SVH
// Register indices; the byte address is four times the index
`define PCFG_IDX_P0_FLAGS  8'h89
`define PCFG_IDX_P1_FLAGS  8'h8A
`define PCFG_IDX_P2_FLAGS  8'h8B
`define PCFG_IDX_P0_MODE   8'h8F
`define PCFG_IDX_P1_MODE   8'hF6
`define PCFG_IDX_P2_MODE   8'hF7
`define PCFG_IDX_P2_DIR    8'hFF
`define PCFG_IDX_EDGE      8'hE0
`define PCFG_IDX_IRQ_STAT  8'hE1
`define PCFG_IDX_IRQ_MASK  8'hE2
// Field positions
`define PCFG_PRIO_HI       7
`define PCFG_PRIO_LO       6
`define PCFG_DIR_HI        4
`define PCFG_PULL2_BIT     7
`define PCFG_PULL1_BIT     6
`define PCFG_PULL0_BIT     5
`define PCFG_USB_BIT       7
`define PCFG_EV_P0         0
`define PCFG_EV_P1         1
`define PCFG_EV_P2         2
// Writable masks and reset values
`define PCFG_PORT2_DIRECTION_PRIORITY_MASK    8'hDF
`define PCFG_P1MODE_MASK   8'hFC
`define PCFG_USB_P0_MASK   8'h3F
`define PCFG_ALL_ONES      8'hFF
`define PCFG_EDGE_MASK     8'h07
`define PCFG_RST8          8'h00
`define PCFG_RST5          5'h00
`define PCFG_RST3          3'h0
`define PCFG_P1_PULL_CAP   8'hFC
`define PCFG_FULL_CAP8     8'hFF
`define PCFG_FULL_CAP5     5'h1F
`endif

/* rtl/pcfg_pkg.sv */
// Types shared by the port configuration block
`default_nettype none
package pcfg_pkg;
   // Peripheral that owns a port 0 pin after arbitration
   typedef enum logic [1:0] {
      PCFG_OWN_NONE,
      PCFG_OWN_SER0,
      PCFG_OWN_SER1,
      PCFG_OWN_TMR
   } pcfg_owner_t;
endpackage
`default_nettype wire

/* rtl/pcfg_edge.sv */
// Per-pin edge detector raising one-cycle events on the chosen edge
`timescale 1ns/10ps
`default_nettype none
`include "pcfg_map.svh"
module pcfg_edge #(
   parameter int W = 8
) (
   input  wire logic         clock_in,    // System clock
   input  wire logic         rst_in,      // Sync reset, high
   input  wire logic [W-1:0] pin_in,      // Pin levels
   input  wire logic         fall_sel_in, // 1 falling, 0 rising
   output logic      [W-1:0] event_out    // Edge seen, one cycle
);
   logic [W-1:0] prev_reg;
   logic         primed_reg;
   logic [W-1:0] event_next;

   // Edge choice; nothing fires before a first sample is held
   assign event_next = !primed_reg ? '0 :
                       fall_sel_in ? (prev_reg & ~pin_in)
                                   : (pin_in & ~prev_reg);

   // Sample history and event register
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         prev_reg   <= '0;
         primed_reg <= 1'b0;
         event_out  <= '0;
      end
      else
      begin
         prev_reg   <= pin_in;
         primed_reg <= 1'b1;
         event_out  <= event_next;
      end
   end

   a_edge_rise : assert property (@(posedge clock_in) disable iff (rst_in)
      (primed_reg && !fall_sel_in && pin_in[0] && !prev_reg[0]) |=> event_out[0])
      else $error("rising edge missed");
endmodule
`default_nettype wire

/* rtl/pcfg_pull.sv */
// Pull-up and pull-down enables for one port
`timescale 1ns/10ps
`default_nettype none
module pcfg_pull #(
   parameter int         W   = 8,
   parameter logic [W-1:0] CAP = '1
) (
   input  wire logic         clock_in, // System clock
   input  wire logic         rst_in,   // Sync reset, high
   input  wire logic [W-1:0] dir_in,   // 1 output
   input  wire logic [W-1:0] tri_in,   // 1 tristate input
   input  wire logic         down_in,  // 1 pull-down, 0 pull-up
   output logic      [W-1:0] up_out,   // Pull-up enable
   output logic      [W-1:0] down_out  // Pull-down enable
);
   logic [W-1:0] pulled;

   // Pull only on capable pins that are inputs in pulled mode
   assign pulled = ~dir_in & ~tri_in & CAP;

   // Registered pad controls
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         up_out   <= '0;
         down_out <= '0;
      end
      else
      begin
         up_out   <= down_in ? '0 : pulled;
         down_out <= down_in ? pulled : '0;
      end
   end

   a_pull_exclusive : assert property (@(posedge clock_in) disable iff (rst_in)
      ((up_out & down_out) == '0) && (((up_out | down_out) & ~CAP) == '0))
      else $error("pull enables overlap");
endmodule
`default_nettype wire

/* bench/pcfg_far_model.sv */
// Far-side model: external pin levels seen by the port block
`timescale 1ns/10ps
`default_nettype none
module pcfg_far_model (
   input  wire logic       clock_in,   // System clock
   input  wire logic [7:0] p0_lvl_in,  // Wanted port 0 levels
   input  wire logic [7:0] p1_lvl_in,  // Wanted port 1 levels
   input  wire logic [4:0] p2_lvl_in,  // Wanted port 2 levels
   output logic      [7:0] p0_pin_out, // Port 0 pins
   output logic      [7:0] p1_pin_out, // Port 1 pins
   output logic      [4:0] p2_pin_out  // Port 2 pins
);
   // Quiet pins at power-up, so no edge is seen out of reset
   initial
   begin
      p0_pin_out = 8'h00;
      p1_pin_out = 8'h00;
      p2_pin_out = 5'h00;
   end
   // Levels move just after an edge; the block samples them synchronously
   always @(posedge clock_in)
   begin
      p0_pin_out <= p0_lvl_in;
      p1_pin_out <= p1_lvl_in;
      p2_pin_out <= p2_lvl_in;
   end
endmodule
`default_nettype wire

/* bench/test_port_pin_config_and_irq_flags.sv */
// Self-checking bench for the port configuration and pin flag block
`timescale 1ns/10ps
`default_nettype none
`include "pcfg_map.svh"
module test_port_pin_config_and_irq_flags;
   import pcfg_pkg::*;
   logic clk, rst, we, cyc, stb, ack, irq, usb;
   logic [9:0] adr;
   logic [31:0] wdat, rdat, rdat_u;
   logic [7:0] rd_u;
   logic [3:0] sel;
   logic [7:0] l0, l1, p0, p1, d0, d1, s0, s1, tlo, thi, pu0, pd0, pu1, pd1;
   logic [4:0] l2, p2, dir2, pu2, pd2;
   pcfg_owner_t [7:0] own;
   int err_count, cmp_count;

   pcfg_port_cfg u_pcfg_port_cfg (
      .clock_in(clk), .rst_in(rst), .wb_adr_in(adr), .wb_dat_in(wdat),
      .wb_dat_out(rdat), .wb_sel_in(sel), .wb_we_in(we), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_ack_out(ack), .p0_pin_in(p0), .p1_pin_in(p1),
      .p2_pin_in(p2), .p0_dir_in(d0), .p1_dir_in(d1), .usb_resume_in(usb),
      .ser0_want_in(s0), .ser1_want_in(s1), .tmr_lo_want_in(tlo),
      .tmr_hi_want_in(thi), .p0_owner_out(own), .port2_pin_direction_out(dir2),
      .p0_pull_up_out(pu0), .p0_pull_down_out(pd0), .p1_pull_up_out(pu1),
      .p1_pull_down_out(pd1), .p2_pull_up_out(pu2), .p2_pull_down_out(pd2),
      .irq_out(irq));

   // USB build on the same bus and pins; only its read data is watched
   pcfg_port_cfg #(.USB_VARIANT(1'b1)) u_pcfg_port_cfg_usb (
      .clock_in(clk), .rst_in(rst), .wb_adr_in(adr), .wb_dat_in(wdat),
      .wb_dat_out(rdat_u), .wb_sel_in(sel), .wb_we_in(we), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_ack_out(), .p0_pin_in(p0), .p1_pin_in(p1),
      .p2_pin_in(p2), .p0_dir_in(d0), .p1_dir_in(d1), .usb_resume_in(usb),
      .ser0_want_in(s0), .ser1_want_in(s1), .tmr_lo_want_in(tlo),
      .tmr_hi_want_in(thi), .p0_owner_out(), .port2_pin_direction_out(),
      .p0_pull_up_out(), .p0_pull_down_out(), .p1_pull_up_out(),
      .p1_pull_down_out(), .p2_pull_up_out(), .p2_pull_down_out(),
      .irq_out());

   pcfg_far_model u_pcfg_far_model (
      .clock_in(clk), .p0_lvl_in(l0), .p1_lvl_in(l1), .p2_lvl_in(l2),
      .p0_pin_out(p0), .p1_pin_out(p1), .p2_pin_out(p2));

   // 50 MHz system clock
   always #10 clk = ~clk;

   task automatic end_sim();
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask

   // Classic Wishbone cycle; request held until ack is sampled high
   task automatic xfer(input logic [7:0] idx, input logic w, input logic [3:0] s,
                       input logic [7:0] wd, output logic [7:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      {cyc, stb, we, sel} <= {2'b11, w, s};
      adr <= {idx, 2'b00};
      wdat <= {24'h0, wd};
      @(posedge clk);
      while (ack !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge clk);
      end
      if (ack !== 1'b1)
      begin
         err_count++;
         end_sim();
      end
      else
      begin
         rd = rdat[7:0];
         rd_u = rdat_u[7:0];
         {cyc, stb, we} <= 3'b000;
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] r;
      xfer(idx, 1'b1, 4'hF, d, r);
   endtask

   task automatic rc(input string nm, input logic [7:0] idx, input logic [7:0] e);
      logic [7:0] r;
      xfer(idx, 1'b0, 4'hF, 8'h00, r);
      chk(nm, {24'h0, r}, {24'h0, e});
   endtask

   // Reset values, an unmapped index, idle pulls and owners
   task automatic t_reset();
      rc("p0 flags", `PCFG_IDX_P0_FLAGS, 8'h00);
      rc("p1 flags", `PCFG_IDX_P1_FLAGS, 8'h00);
      rc("p2 flags", `PCFG_IDX_P2_FLAGS, 8'h00);
      rc("p0 mode", `PCFG_IDX_P0_MODE, 8'h00);
      rc("p1 mode", `PCFG_IDX_P1_MODE, 8'h00);
      rc("p2 mode", `PCFG_IDX_P2_MODE, 8'h00);
      rc("p2 dir", `PCFG_IDX_P2_DIR, 8'h00);
      rc("unmapped", 8'h40, 8'h00);
      chk("p0 up", pu0, 8'hFF);
      chk("p1 up", pu1, 8'hFC);
      chk("p2 up", pu2, 5'h1F);
      chk("owners idle", own, 16'h0000);
   endtask

   // Writable masks, byte select, pull selection against mode and direction
   task automatic t_cfg();
      logic [7:0] r;
      wr(`PCFG_IDX_P2_DIR, 8'hFF);
      wr(`PCFG_IDX_P0_MODE, 8'hFF);
      wr(`PCFG_IDX_P1_MODE, 8'hFF);
      rc("p2 dir ro bit", `PCFG_IDX_P2_DIR, 8'hDF);
      rc("p1 mode ro bits", `PCFG_IDX_P1_MODE, 8'hFC);
      chk("p2 dir out", dir2, 5'h1F);
      chk("p0 up tristate", pu0, 8'h00);
      chk("p1 up tristate", pu1, 8'h00);
      chk("p2 up output", pu2, 5'h00);
      // Cleared low byte select must not write
      xfer(`PCFG_IDX_P0_MODE, 1'b1, 4'hE, 8'h00, r);
      rc("p0 mode sel", `PCFG_IDX_P0_MODE, 8'hFF);
      wr(`PCFG_IDX_P0_MODE, 8'h0F);
      wr(`PCFG_IDX_P1_MODE, 8'h00);
      wr(`PCFG_IDX_P2_DIR, 8'h00);
      wr(`PCFG_IDX_P2_MODE, 8'hE3);
      d0 <= 8'h10;
      d1 <= 8'h80;
      repeat (3) @(posedge clk);
      chk("p0 down", pd0, 8'hE0);
      chk("p0 up", pu0, 8'h00);
      chk("p1 down", pd1, 8'h7C);
      chk("p2 down", pd2, 5'h1C);
      chk("p2 up", pu2, 5'h00);
      chk("p2 dir in", dir2, 5'h00);
      rc("p2 mode rb", `PCFG_IDX_P2_MODE, 8'hE3);
   endtask

   // Conflicting requests on pins 0..2 under all four priority codes
   task automatic t_prio();
      logic [15:0] ex [4];
      logic [1:0] p;
      ex = '{16'h0059, 16'h005A, 16'h005D, 16'h0079};
      s0 <= 8'h0D;
      s1 <= 8'h03;
      tlo <= 8'h02;
      thi <= 8'h04;
      for (int i = 0; i < 4; i++)
      begin
         p = i[1:0];
         wr(`PCFG_IDX_P2_DIR, {p, 6'h00});
         repeat (3) @(posedge clk);
         chk("owners", own, ex[i]);
         rc("prio rb", `PCFG_IDX_P2_DIR, {p, 6'h00});
      end
   endtask

   // Sticky flags, write-zero clear, read-clear status, mask, edge select
   task automatic t_flags();
      wr(`PCFG_IDX_IRQ_MASK, 8'h07);
      l0 <= 8'h04;
      l1 <= 8'h80;
      l2 <= 5'h10;
      repeat (5) @(posedge clk);
      chk("irq set", irq, 1'b1);
      rc("p0 rise", `PCFG_IDX_P0_FLAGS, 8'h04);
      rc("p1 rise", `PCFG_IDX_P1_FLAGS, 8'h80);
      rc("p2 rise", `PCFG_IDX_P2_FLAGS, 8'h10);
      wr(`PCFG_IDX_P0_FLAGS, 8'hFF);
      wr(`PCFG_IDX_P2_FLAGS, 8'hFF);
      rc("p0 keep", `PCFG_IDX_P0_FLAGS, 8'h04);
      rc("p2 keep", `PCFG_IDX_P2_FLAGS, 8'h10);
      wr(`PCFG_IDX_P0_FLAGS, 8'hFB);
      wr(`PCFG_IDX_P1_FLAGS, 8'h7F);
      wr(`PCFG_IDX_P2_FLAGS, 8'hEF);
      rc("p0 clr", `PCFG_IDX_P0_FLAGS, 8'h00);
      rc("p1 clr", `PCFG_IDX_P1_FLAGS, 8'h00);
      rc("p2 clr", `PCFG_IDX_P2_FLAGS, 8'h00);
      rc("stat", `PCFG_IDX_IRQ_STAT, 8'h07);
      rc("stat rc", `PCFG_IDX_IRQ_STAT, 8'h00);
      repeat (2) @(posedge clk);
      chk("irq clr", irq, 1'b0);
      // Falling edges now flag; masked status keeps irq low
      wr(`PCFG_IDX_EDGE, 8'h07);
      wr(`PCFG_IDX_IRQ_MASK, 8'h00);
      l0 <= 8'h00;
      l1 <= 8'h00;
      l2 <= 5'h00;
      repeat (5) @(posedge clk);
      chk("irq masked", irq, 1'b0);
      rc("p0 fall", `PCFG_IDX_P0_FLAGS, 8'h04);
      rc("p1 fall", `PCFG_IDX_P1_FLAGS, 8'h80);
      rc("p2 fall", `PCFG_IDX_P2_FLAGS, 8'h10);
      rc("stat masked", `PCFG_IDX_IRQ_STAT, 8'h07);
   endtask

   // Pins 7:6 flag only in the plain build; resume sets bit 7 only in the USB build
   task automatic t_usb();
      logic [7:0] r;
      wr(`PCFG_IDX_P0_FLAGS, 8'h00);
      wr(`PCFG_IDX_EDGE, 8'h00);
      l0 <= 8'hC0;
      repeat (5) @(posedge clk);
      usb <= 1'b1;
      @(posedge clk);
      usb <= 1'b0;
      xfer(`PCFG_IDX_P0_FLAGS, 1'b0, 4'hF, 8'h00, r);
      chk("p0 pins 7:6", r, 8'hC0);
      chk("usb resume", rd_u, 8'h80);
      wr(`PCFG_IDX_P0_FLAGS, 8'h7F);
      xfer(`PCFG_IDX_P0_FLAGS, 1'b0, 4'hF, 8'h00, r);
      chk("p0 keep 6", r, 8'h40);
      chk("usb clear", rd_u, 8'h00);
   endtask

   // Main sequence
   initial
   begin
      {clk, rst, we, cyc, stb, usb} = 6'b010000;
      {adr, wdat, sel} = '0;
      {l0, l1, l2, d0, d1, s0, s1, tlo, thi} = '0;
      err_count = 0;
      cmp_count = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_cfg();
      t_prio();
      t_flags();
      t_usb();
      end_sim();
   end
endmodule
`default_nettype wire
